// [gp_timer.sv]
// general-purpose timer with watchdog mode behind an ahb-lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module gp_timer
  import gp_timer_pkg::*;
#(
  // identity value, arbitrary
  parameter logic [31:0] ID_VALUE = 32'h0000_5a01
) (
  // clock, reset, clock enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // external clock / event pin
  input wire logic i_timer_event_input,
  // event outputs, one-cycle pulses
  output logic o_int_lo,
  output logic o_int_hi,
  output logic o_dma_sync_lo,
  output logic o_dma_sync_hi,
  output logic o_rto_trigger,
  output logic o_device_reset
);

  timer_state_s s_reg; // all flops
  timer_state_s s_next; // their next value

  // increment and compare results of the two halves
  logic [31:0] inc_lo;
  logic [31:0] inc_hi;
  logic m_lo;
  logic m_hi;
  logic ones_lo;

  // decoded control, shared with the checks below
  logic edge_in; // rising edge on the event pin
  logic tick; // one counting step
  logic run_lo; // low half (or whole counter) runs
  logic run_hi; // high half runs
  logic end_lo; // period end reported on the low side
  logic end_hi; // period end reported on the high side
  logic ap; // ahb address phase taken
  logic rd_clear; // counter read with read-reset set

  gp_timer_half_step u_lo (
    .i_count(s_reg.cnt_lo),
    .i_period(s_reg.prd_lo),
    .o_incr(inc_lo),
    .o_match(m_lo),
    .o_all_ones(ones_lo)
  );

  gp_timer_half_step u_hi (
    .i_count(s_reg.cnt_hi),
    .i_period(s_reg.prd_hi),
    .o_incr(inc_hi),
    .o_match(m_hi),
    .o_all_ones() // high half never carries further
  );

  // next-state logic: counting, bus, capture and events
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wd;
    logic wide_end;
    rd = WORD_RESET;
    wd = i_hwdata;
    wide_end = 1'b0;
    s_next = s_reg;
    end_lo = 1'b0;
    end_hi = 1'b0;
    // pin is synchronous to i_clk; one flop gives the edge
    edge_in = i_timer_event_input & ~s_reg.ev_prev;
    s_next.ev_prev = i_timer_event_input;
    tick = s_reg.ext_clk ? edge_in : 1'b1;
    run_lo = (s_reg.mode_lo != RUN_OFF);
    // reserved split code behaves as dual, so the high half keeps its own mode
    run_hi = (s_reg.split == SPLIT_DUAL || s_reg.split == SPLIT_RSVD) ?
             (s_reg.mode_hi != RUN_OFF) : run_lo;
    ap = i_hsel & i_htrans[1] & i_hready & (i_hsize == HSIZE_WORD);
    rd_clear = ap & ~i_hwrite & (i_haddr[7:0] == ADDR_CNT_LO) & s_reg.rd_rst;

    // counting, by split mode
    case (s_reg.split)
      SPLIT_DUAL, SPLIT_RSVD: begin
        // two independent halves, each against its own period
        if (run_lo && tick) begin
          if (m_lo) begin
            s_next.cnt_lo = WORD_RESET;
            end_lo = 1'b1;
          end else begin
            s_next.cnt_lo = inc_lo;
          end
        end
        if (run_hi && tick) begin
          if (m_hi) begin
            s_next.cnt_hi = WORD_RESET;
            end_hi = 1'b1;
          end else begin
            s_next.cnt_hi = inc_hi;
          end
        end
      end
      SPLIT_CHAIN: begin
        // low half is a prescaler; its wraps step the high half
        if (run_lo && tick) begin
          if (m_lo) begin
            s_next.cnt_lo = WORD_RESET;
            if (m_hi) begin
              s_next.cnt_hi = WORD_RESET;
              end_hi = 1'b1;
            end else begin
              s_next.cnt_hi = inc_hi;
            end
          end else begin
            s_next.cnt_lo = inc_lo;
          end
        end
      end
      default: begin
        // one 64-bit counter; the period end is both halves matching
        if (run_lo && tick) begin
          if (m_lo && m_hi) begin
            s_next.cnt_lo = WORD_RESET;
            s_next.cnt_hi = WORD_RESET;
            end_lo = 1'b1;
          end else begin
            s_next.cnt_lo = inc_lo;
            if (ones_lo) begin
              s_next.cnt_hi = inc_hi;
            end
          end
        end
      end
    endcase

    // what a period end does to the run mode and period
    if (s_reg.split == SPLIT_DUAL || s_reg.split == SPLIT_RSVD) begin
      if (end_lo && s_reg.mode_lo == RUN_ONCE) begin
        s_next.mode_lo = RUN_OFF;
      end
      if (end_lo && s_reg.mode_lo == RUN_RELOAD) begin
        s_next.prd_lo = s_reg.rel_lo;
      end
      if (end_hi && s_reg.mode_hi == RUN_ONCE) begin
        s_next.mode_hi = RUN_OFF;
      end
      if (end_hi && s_reg.mode_hi == RUN_RELOAD) begin
        s_next.prd_hi = s_reg.rel_hi;
      end
    end else begin
      // wide modes: the low-half mode field governs the whole counter
      wide_end = end_lo | end_hi;
      if (wide_end && s_reg.mode_lo == RUN_ONCE) begin
        s_next.mode_lo = RUN_OFF;
      end
      if (wide_end && s_reg.mode_lo == RUN_RELOAD) begin
        s_next.prd_lo = s_reg.rel_lo;
        s_next.prd_hi = s_reg.rel_hi;
      end
    end

    // capture the count as it stood before this step
    if (s_reg.cap_en && edge_in) begin
      s_next.cap_lo = s_reg.cnt_lo;
      s_next.cap_hi = s_reg.cnt_hi;
    end

    // data phase of a write: latched address, hwdata now valid
    if (s_reg.wr_pend) begin
      if (s_reg.wr_addr == ADDR_EMU) begin
        s_next.emu = wd[1:0];
      end else if (s_reg.wr_addr == ADDR_CNT_LO) begin
        s_next.cnt_lo = wd;
      end else if (s_reg.wr_addr == ADDR_CNT_HI) begin
        s_next.cnt_hi = wd;
      end else if (s_reg.wr_addr == ADDR_PRD_LO) begin
        s_next.prd_lo = wd;
      end else if (s_reg.wr_addr == ADDR_PRD_HI) begin
        s_next.prd_hi = wd;
      end else if (s_reg.wr_addr == ADDR_CTRL) begin
        s_next.mode_lo = run_mode_e'(wd[CTRL_MODE_LO_POS +: 2]);
        s_next.ext_clk = wd[CTRL_EXT_POS];
        s_next.rd_rst = wd[CTRL_RDRST_POS];
        s_next.cap_en = wd[CTRL_CAPEN_POS];
        s_next.mode_hi = run_mode_e'(wd[CTRL_MODE_HI_POS +: 2]);
      end else if (s_reg.wr_addr == ADDR_GCTRL) begin
        s_next.split = split_e'(wd[GCTRL_SPLIT_POS +: 2]);
      end else if (s_reg.wr_addr == ADDR_WDCTRL) begin
        s_next.wd_en = wd[WD_EN_POS];
      end else if (s_reg.wr_addr == ADDR_REL_LO) begin
        s_next.rel_lo = wd;
      end else if (s_reg.wr_addr == ADDR_REL_HI) begin
        s_next.rel_hi = wd;
      end else if (s_reg.wr_addr == ADDR_INT) begin
        s_next.int_en_lo = wd[INT_EN_LO_POS];
        s_next.int_en_hi = wd[INT_EN_HI_POS];
        // status bits clear on writing one
        if (wd[INT_ST_LO_POS]) begin
          s_next.int_st_lo = 1'b0;
        end
        if (wd[INT_ST_HI_POS]) begin
          s_next.int_st_hi = 1'b0;
        end
      end
      // other offsets, including read-only ones: write ignored
    end

    // address phase: read data is fetched now so it leaves a flop
    if (ap && !i_hwrite) begin
      if (i_haddr[7:0] == ADDR_ID) begin
        rd = ID_VALUE;
      end else if (i_haddr[7:0] == ADDR_EMU) begin
        rd[1:0] = s_reg.emu;
      end else if (i_haddr[7:0] == ADDR_CNT_LO) begin
        rd = s_reg.cnt_lo;
      end else if (i_haddr[7:0] == ADDR_CNT_HI) begin
        rd = s_reg.cnt_hi;
      end else if (i_haddr[7:0] == ADDR_PRD_LO) begin
        rd = s_reg.prd_lo;
      end else if (i_haddr[7:0] == ADDR_PRD_HI) begin
        rd = s_reg.prd_hi;
      end else if (i_haddr[7:0] == ADDR_CTRL) begin
        rd[CTRL_MODE_LO_POS +: 2] = s_reg.mode_lo;
        rd[CTRL_EXT_POS] = s_reg.ext_clk;
        rd[CTRL_RDRST_POS] = s_reg.rd_rst;
        rd[CTRL_CAPEN_POS] = s_reg.cap_en;
        rd[CTRL_MODE_HI_POS +: 2] = s_reg.mode_hi;
      end else if (i_haddr[7:0] == ADDR_GCTRL) begin
        rd[GCTRL_SPLIT_POS +: 2] = s_reg.split;
      end else if (i_haddr[7:0] == ADDR_WDCTRL) begin
        rd[WD_EN_POS] = s_reg.wd_en;
      end else if (i_haddr[7:0] == ADDR_REL_LO) begin
        rd = s_reg.rel_lo;
      end else if (i_haddr[7:0] == ADDR_REL_HI) begin
        rd = s_reg.rel_hi;
      end else if (i_haddr[7:0] == ADDR_CAP_LO) begin
        rd = s_reg.cap_lo;
      end else if (i_haddr[7:0] == ADDR_CAP_HI) begin
        rd = s_reg.cap_hi;
      end else if (i_haddr[7:0] == ADDR_INT) begin
        rd[INT_EN_LO_POS] = s_reg.int_en_lo;
        rd[INT_ST_LO_POS] = s_reg.int_st_lo;
        rd[INT_EN_HI_POS] = s_reg.int_en_hi;
        rd[INT_ST_HI_POS] = s_reg.int_st_hi;
      end
      // unmapped offsets read as zero with an okay response
    end
    s_next.hrdata = rd;
    s_next.wr_pend = ap & i_hwrite;
    s_next.wr_addr = i_haddr[7:0];
    s_next.hready = 1'b1; // zero wait states
    // read-reset wins over a counter write in the same cycle
    if (rd_clear) begin
      s_next.cnt_lo = WORD_RESET;
      s_next.cnt_hi = WORD_RESET;
    end

    // sticky status: a new event wins over a software clear
    if (end_lo) begin
      s_next.int_st_lo = 1'b1;
    end
    if (end_hi) begin
      s_next.int_st_hi = 1'b1;
    end
    s_next.int_lo = end_lo & s_reg.int_en_lo;
    s_next.int_hi = end_hi & s_reg.int_en_hi;
    s_next.dma_lo = end_lo;
    s_next.dma_hi = end_hi;
    s_next.real_time_output_module = end_lo | end_hi;
    s_next.wd_rst = s_reg.wd_en & (end_lo | end_hi);
  end

  // the only clocked process; a low clock enable freezes everything
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_reg <= STATE_RESET;
    end else if (i_ce) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops, except hresp, which is tied to okay
  assign o_hrdata = s_reg.hrdata;
  assign o_hreadyout = s_reg.hready;
  assign o_hresp = 1'b0;
  assign o_int_lo = s_reg.int_lo;
  assign o_int_hi = s_reg.int_hi;
  assign o_dma_sync_lo = s_reg.dma_lo;
  assign o_dma_sync_hi = s_reg.dma_hi;
  assign o_rto_trigger = s_reg.real_time_output_module;
  assign o_device_reset = s_reg.wd_rst;

  // checks; no bus write or counter read in flight keeps them exact
  logic quiet;
  assign quiet = i_ce & ~s_reg.wr_pend & ~rd_clear;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_WRAP_64: assert property (
    quiet && s_reg.split == SPLIT_64 && run_lo && tick && ones_lo && !m_lo
    |=> s_reg.cnt_hi == $past(s_reg.cnt_hi) + 32'h0000_0001 && s_reg.cnt_lo == 32'h0000_0000)
    else $error("64-bit carry into high half lost");
  AST_ONCE_STOPS: assert property (
    quiet && s_reg.split == SPLIT_64 && end_lo && s_reg.mode_lo == RUN_ONCE
    |=> s_reg.mode_lo == RUN_OFF ##1 (s_reg.cnt_lo == 32'h0000_0000 || !i_ce))
    else $error("one-shot did not stop");
  AST_CONT_WRAP: assert property (
    quiet && s_reg.split == SPLIT_DUAL && s_reg.mode_lo == RUN_CONT && tick && m_lo
    |=> s_reg.cnt_lo == 32'h0000_0000 && s_reg.mode_lo == RUN_CONT)
    else $error("continuous half did not wrap");
  AST_RELOAD: assert property (
    quiet && s_reg.split == SPLIT_DUAL && end_lo && s_reg.mode_lo == RUN_RELOAD
    |=> s_reg.prd_lo == $past(s_reg.rel_lo))
    else $error("period not reloaded");
  AST_EXT_HOLD: assert property (
    quiet && s_reg.ext_clk && !edge_in |=> $stable(s_reg.cnt_lo))
    else $error("counted without external edge");
  AST_CAPTURE: assert property (
    i_ce && s_reg.cap_en && edge_in |=> s_reg.cap_lo == $past(s_reg.cnt_lo))
    else $error("capture missed");
  AST_READ_RESET: assert property (
    i_ce && rd_clear |=> s_reg.cnt_lo == 32'h0000_0000 && s_reg.cnt_hi == 32'h0000_0000)
    else $error("read-reset did not clear");
  AST_INT: assert property (
    i_ce && end_lo && s_reg.int_en_lo |=> o_int_lo && s_reg.int_st_lo
    ##1 (!o_int_lo || !i_ce || $past(end_lo)))
    else $error("interrupt pulse wrong");
  AST_DMA: assert property (
    i_ce && end_hi |=> o_dma_sync_hi)
    else $error("dma sync missing");
  AST_RTO: assert property (
    o_rto_trigger && $past(i_ce) |-> $past(end_lo) || $past(end_hi))
    else $error("rto trigger without period end");
  AST_WATCHDOG: assert property (
    i_ce && s_reg.wd_en && (end_lo || end_hi) |=> o_device_reset)
    else $error("watchdog expiry did not reset");
  AST_CHAIN: assert property (
    quiet && s_reg.split == SPLIT_CHAIN && run_lo && tick && !m_lo |=> $stable(s_reg.cnt_hi))
    else $error("chained high half stepped early");

  COV_ONCE: cover property (end_lo && s_reg.mode_lo == RUN_ONCE);
  COV_CHAIN_END: cover property (end_hi && s_reg.split == SPLIT_CHAIN);
  COV_CAPTURE: cover property (s_reg.cap_en && edge_in && i_ce);
  COV_WATCHDOG: cover property (o_device_reset);

endmodule
`default_nettype wire

// [gp_timer_half_step.sv]
// one 32-bit counter half: increment, period match and all-ones detect
`timescale 1ns/100ps
`default_nettype none
module gp_timer_half_step (
  // counter and its period
  input wire logic [31:0] i_count,
  input wire logic [31:0] i_period,
  // next count and compare results
  output logic [31:0] o_incr,
  output logic o_match,
  output logic o_all_ones
);

  // purely combinational; the owner holds the flops
  always_comb begin
    o_incr = i_count + 32'h0000_0001;
    o_match = (i_count == i_period);
    o_all_ones = (i_count == 32'hffff_ffff);
  end

endmodule
`default_nettype wire

// [gp_timer_pkg.sv]
// package: register map, field positions, modes and state type of the timer
package gp_timer_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_ID = 8'h00;
  localparam logic [7:0] ADDR_EMU = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h10;
  localparam logic [7:0] ADDR_CNT_HI = 8'h14;
  localparam logic [7:0] ADDR_PRD_LO = 8'h18;
  localparam logic [7:0] ADDR_PRD_HI = 8'h1c;
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_GCTRL = 8'h24;
  localparam logic [7:0] ADDR_WDCTRL = 8'h28;
  localparam logic [7:0] ADDR_REL_LO = 8'h34;
  localparam logic [7:0] ADDR_REL_HI = 8'h38;
  localparam logic [7:0] ADDR_CAP_LO = 8'h3c;
  localparam logic [7:0] ADDR_CAP_HI = 8'h40;
  localparam logic [7:0] ADDR_INT = 8'h44;

  // timer_control field positions
  localparam int CTRL_MODE_LO_POS = 6;
  localparam int CTRL_EXT_POS = 8;
  localparam int CTRL_RDRST_POS = 10;
  localparam int CTRL_CAPEN_POS = 11;
  localparam int CTRL_MODE_HI_POS = 22;
  // timer_global_control split field
  localparam int GCTRL_SPLIT_POS = 2;
  // watchdog_control enable
  localparam int WD_EN_POS = 14;
  // interrupt_control_and_status fields
  localparam int INT_EN_LO_POS = 0;
  localparam int INT_ST_LO_POS = 1;
  localparam int INT_EN_HI_POS = 16;
  localparam int INT_ST_HI_POS = 17;

  // values after reset
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] EMU_RESET = 2'h0;

  // ahb-lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // run mode of a half (or of the whole counter)
  typedef enum logic [1:0] {
    RUN_OFF = 2'b00,
    RUN_ONCE = 2'b01,
    RUN_CONT = 2'b10,
    RUN_RELOAD = 2'b11
  } run_mode_e;

  // how the two halves are combined
  typedef enum logic [1:0] {
    SPLIT_64 = 2'b00,
    SPLIT_DUAL = 2'b01,
    SPLIT_RSVD = 2'b10,
    SPLIT_CHAIN = 2'b11
  } split_e;

  // whole state of the timer block
  typedef struct packed {
    logic [31:0] cnt_lo;
    logic [31:0] cnt_hi;
    logic [31:0] prd_lo;
    logic [31:0] prd_hi;
    logic [31:0] rel_lo;
    logic [31:0] rel_hi;
    logic [31:0] cap_lo;
    logic [31:0] cap_hi;
    run_mode_e mode_lo;
    run_mode_e mode_hi;
    logic ext_clk;
    logic rd_rst;
    logic cap_en;
    split_e split;
    logic wd_en;
    logic [1:0] emu;
    logic int_en_lo;
    logic int_en_hi;
    logic int_st_lo;
    logic int_st_hi;
    logic ev_prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hready;
    logic int_lo;
    logic int_hi;
    logic dma_lo;
    logic dma_hi;
    logic real_time_output_module;
    logic wd_rst;
  } timer_state_s;

  localparam timer_state_s STATE_RESET = '{
    cnt_lo: WORD_RESET, cnt_hi: WORD_RESET, prd_lo: WORD_RESET, prd_hi: WORD_RESET,
    rel_lo: WORD_RESET, rel_hi: WORD_RESET, cap_lo: WORD_RESET, cap_hi: WORD_RESET,
    mode_lo: RUN_OFF, mode_hi: RUN_OFF, split: SPLIT_64, emu: EMU_RESET,
    wr_addr: ADDR_ID, hrdata: WORD_RESET, hready: 1'b1, default: 1'b0};

endpackage

// [gp_timer_tb.sv]
// self-checking bench for the general-purpose timer: bus access, modes and event pulses
`timescale 1ns/100ps
`default_nettype none
module tb;
  import gp_timer_pkg::*;

  // identity value handed to the design, arbitrary
  localparam logic [31:0] ID_TEST = 32'h0000_3c07;

  // clock, reset and bus signals driven by the bench
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic pin = 1'b0;
  // design outputs
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  wire [5:0] ev;
  // pulse bookkeeping: count, last cycle and spacing per event output
  int np[6];
  int last[6];
  int gap[6];
  int base[6];
  int cyc = 0;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] v1;
  logic [31:0] v2;

  // free-running 100 MHz clock
  always #5 i_clk = ~i_clk;

  gp_timer #(.ID_VALUE(ID_TEST)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_timer_event_input(pin),
    .o_int_lo(ev[0]), .o_int_hi(ev[1]), .o_dma_sync_lo(ev[2]), .o_dma_sync_hi(ev[3]),
    .o_rto_trigger(ev[4]), .o_device_reset(ev[5])
  );

  // records every event pulse; spacing tells the period without peeking inside
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++) begin
      if (ev[i] === 1'b1) begin
        np[i] <= np[i] + 1;
        gap[i] <= cyc - last[i];
        last[i] <= cyc;
      end
    end
  end

  // single comparison point
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ahb-lite single word write; request held until hready is seen high
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
  endtask

  // ahb-lite single word read; data taken at the edge that ends the data phase
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    do @(posedge i_clk); while (hreadyout !== 1'b1);
    d = hrdata;
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  // read and compare in one go
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  // lets the timer run, remembering pulse counts at the start
  task automatic idle(input int n);
    for (int i = 0; i < 6; i++) begin
      base[i] = np[i];
    end
    repeat (n) @(posedge i_clk);
  endtask

  // number of pulses on one output since the last idle started
  function automatic logic [31:0] delta(input int i);
    return 32'(np[i] - base[i]);
  endfunction

  // timer_control word built from field positions
  function automatic logic [31:0] ctrl(input logic [1:0] ml, input logic [1:0] mh,
                                       input logic ext, input logic rr, input logic cp);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_MODE_LO_POS +: 2] = ml;
    w[CTRL_MODE_HI_POS +: 2] = mh;
    w[CTRL_EXT_POS] = ext;
    w[CTRL_RDRST_POS] = rr;
    w[CTRL_CAPEN_POS] = cp;
    return w;
  endfunction

  // prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the roughly 530 cycles the tests take
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    stop_test();
  end

  // address table of resettable registers
  logic [7:0] regs[13] = '{ADDR_EMU, ADDR_CNT_LO, ADDR_CNT_HI, ADDR_PRD_LO, ADDR_PRD_HI,
    ADDR_CTRL, ADDR_GCTRL, ADDR_WDCTRL, ADDR_REL_LO, ADDR_REL_HI, ADDR_CAP_LO,
    ADDR_CAP_HI, ADDR_INT};

  // main sequence
  initial begin
    for (int i = 0; i < 6; i++) begin
      np[i] = 0;
      last[i] = 0;
      gap[i] = 0;
    end
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    // reset values, identity, unmapped place and read-only places
    rdc(ADDR_ID, ID_TEST);
    foreach (regs[i]) rdc(regs[i], WORD_RESET);
    rdc(8'h08, 32'h0000_0000);
    wr(8'h2c, 32'hffff_ffff);
    wr(ADDR_CAP_LO, 32'h1234_5678);
    wr(ADDR_ID, 32'h0000_0000);
    rdc(8'h2c, 32'h0000_0000);
    rdc(ADDR_CAP_LO, 32'h0000_0000);
    rdc(ADDR_ID, ID_TEST);
    wr(ADDR_REL_HI, 32'ha5a5_5a5a);
    wr(ADDR_EMU, 32'h0000_0003);
    rdc(ADDR_REL_HI, 32'ha5a5_5a5a);
    rdc(ADDR_EMU, 32'h0000_0003);
    // dual unchained continuous: halves keep their own periods, masked events silent
    wr(ADDR_GCTRL, 32'h0000_0004);
    wr(ADDR_PRD_LO, 32'h0000_0002);
    wr(ADDR_PRD_HI, 32'h0000_0004);
    wr(ADDR_CTRL, ctrl(RUN_CONT, RUN_CONT, 1'b0, 1'b0, 1'b0));
    idle(40);
    check(32'(gap[2]), 32'h0000_0003);
    check(32'(gap[3]), 32'h0000_0005);
    check(32'(gap[4]), 32'h0000_0001);
    check(delta(0), 32'h0000_0000);
    check(delta(5), 32'h0000_0000);
    wr(ADDR_INT, 32'h0001_0001);
    wr(ADDR_WDCTRL, 32'h0000_4000);
    idle(40);
    check(32'(gap[0]), 32'h0000_0003);
    check(32'(gap[1]), 32'h0000_0005);
    check(32'(gap[5]), 32'h0000_0003);
    rdc(ADDR_INT, 32'h0003_0003);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_WDCTRL, 32'h0000_0000);
    wr(ADDR_INT, 32'h0002_0002);
    rdc(ADDR_INT, 32'h0000_0000);
    // one-shot: a single period end, then the mode drops to off
    wr(ADDR_CNT_LO, 32'h0000_0000);
    wr(ADDR_PRD_LO, 32'h0000_0005);
    wr(ADDR_CTRL, ctrl(RUN_ONCE, RUN_OFF, 1'b0, 1'b0, 1'b0));
    idle(40);
    check(delta(2), 32'h0000_0001);
    rdc(ADDR_CTRL, 32'h0000_0000);
    rdc(ADDR_CNT_LO, 32'h0000_0000);
    // 64-bit: the carry out of the low half is needed to reach the period
    wr(ADDR_GCTRL, 32'h0000_0000);
    wr(ADDR_CNT_LO, 32'hffff_fffe);
    wr(ADDR_CNT_HI, 32'h0000_0000);
    wr(ADDR_PRD_LO, 32'h0000_0000);
    wr(ADDR_PRD_HI, 32'h0000_0001);
    wr(ADDR_CTRL, ctrl(RUN_ONCE, RUN_OFF, 1'b0, 1'b0, 1'b0));
    idle(20);
    check(delta(2), 32'h0000_0001);
    check(delta(3), 32'h0000_0000);
    rdc(ADDR_CNT_HI, 32'h0000_0000);
    // chained: low half prescales by two, high half period three
    wr(ADDR_GCTRL, 32'h0000_000c);
    wr(ADDR_PRD_LO, 32'h0000_0001);
    wr(ADDR_PRD_HI, 32'h0000_0002);
    wr(ADDR_CTRL, ctrl(RUN_CONT, RUN_OFF, 1'b0, 1'b0, 1'b0));
    idle(40);
    check(32'(gap[3]), 32'h0000_0006);
    wr(ADDR_CTRL, 32'h0000_0000);
    // reload: first period from the period register, then from reload
    wr(ADDR_GCTRL, 32'h0000_0004);
    wr(ADDR_CNT_LO, 32'h0000_0000);
    wr(ADDR_REL_LO, 32'h0000_0004);
    wr(ADDR_CTRL, ctrl(RUN_RELOAD, RUN_OFF, 1'b0, 1'b0, 1'b0));
    idle(40);
    check(32'(gap[2]), 32'h0000_0005);
    rdc(ADDR_PRD_LO, 32'h0000_0004);
    wr(ADDR_CTRL, 32'h0000_0000);
    // reserved split code acts as dual: high half alone, one-shot
    wr(ADDR_GCTRL, 32'h0000_0008);
    wr(ADDR_CNT_HI, 32'h0000_0000);
    wr(ADDR_PRD_HI, 32'h0000_0003);
    wr(ADDR_CTRL, ctrl(RUN_OFF, RUN_ONCE, 1'b0, 1'b0, 1'b0));
    idle(30);
    check(delta(3), 32'h0000_0001);
    check(delta(2), 32'h0000_0000);
    rdc(ADDR_CTRL, 32'h0000_0000);
    // external clock with capture: three pin edges step the count three times
    wr(ADDR_CNT_LO, 32'h0000_0000);
    wr(ADDR_PRD_LO, 32'h0000_000a);
    wr(ADDR_CTRL, ctrl(RUN_CONT, RUN_OFF, 1'b1, 1'b0, 1'b1));
    repeat (3) begin
      @(posedge i_clk);
      pin <= 1'b1;
      @(posedge i_clk);
      pin <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    rdc(ADDR_CAP_LO, 32'h0000_0002);
    rdc(ADDR_CNT_LO, 32'h0000_0003);
    // clock enable low freezes the edge detector: a pin pulse meanwhile is lost
    i_ce <= 1'b0;
    @(posedge i_clk);
    pin <= 1'b1;
    @(posedge i_clk);
    pin <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_ce <= 1'b1;
    rdc(ADDR_CNT_LO, 32'h0000_0003);
    rdc(ADDR_CAP_LO, 32'h0000_0002);
    // read-reset: a counter read restarts the count from zero
    wr(ADDR_PRD_LO, 32'hffff_ffff);
    wr(ADDR_CTRL, ctrl(RUN_CONT, RUN_OFF, 1'b0, 1'b1, 1'b0));
    repeat (20) @(posedge i_clk);
    rd(ADDR_CNT_LO, v1);
    rd(ADDR_CNT_LO, v2);
    check({31'h0000_0000, v1 > 32'h0000_0010}, 32'h0000_0001);
    check({31'h0000_0000, v2 < 32'h0000_0008}, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    stop_test();
  end
endmodule
`default_nettype wire
